// >>> src/isc_pkg.sv
// Constants, types and state record for the I2C timing and FIFO counter block.
// Assumes one 125 MHz APB clock pclk and an active-low asynchronous reset.

package isc_pkg;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [31:0] ADDR_HI_DIV  = 32'h8002_080C;
  localparam logic [31:0] ADDR_LO_DIV  = 32'h8002_0810;
  localparam logic [31:0] ADDR_OWN     = 32'h8002_0814;
  localparam logic [31:0] ADDR_RX_LVL  = 32'h8002_0818;
  localparam logic [31:0] ADDR_TX_LVL  = 32'h8002_081C;
  localparam logic [31:0] ADDR_RX_CNT  = 32'h8002_0820;
  localparam logic [31:0] ADDR_TX_CNT  = 32'h8002_0824;
  localparam logic [31:0] ADDR_TT_PORT = 32'h8002_0828;
  localparam logic [31:0] ADDR_TT_LVL  = 32'h8002_082C;
  localparam logic [31:0] ADDR_CTRL    = 32'h8002_0830;
  localparam logic [31:0] ADDR_TX_DATA = 32'h8002_0834;
  localparam logic [31:0] ADDR_RX_DATA = 32'h8002_0838;
  localparam logic [14:0] DIV_RESET    = 15'h752E;
  localparam logic [6:0]  OWN_RESET    = 7'h1A;
  localparam int          CTRL_MEN     = 0;
  localparam int          CTRL_TEN     = 1;
  localparam int          CTRL_SRST    = 8;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          LVL_W        = 5;
  localparam logic [3:0]  ACK_BIT      = 4'h8;
  localparam logic [2:0]  LAST_BIT     = 3'h7;

  // ****************************************************************
  // State machines and the state record of the top module
  // ****************************************************************
  typedef enum logic [2:0] {M_IDLE, M_START, M_LOW, M_HIGH, M_STOP1, M_STOP2} isc_mst_t;
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK, T_RX, T_TX, T_TXACK} isc_tgt_t;

  typedef struct packed {
    isc_mst_t    mst;
    isc_tgt_t    tgt;
    logic [14:0] hi;
    logic [14:0] lo;
    logic [6:0]  own;
    logic        men;
    logic        ten;
    logic        srst;
    logic [14:0] cnt;
    logic [3:0]  mbit;
    logic [7:0]  msh;
    logic        mscl;
    logic        msda;
    logic [2:0]  tbit;
    logic [7:0]  tsh;
    logic        tsda;
    logic        ackd;
    logic        rw;
    logic        tack;
    logic [6:0]  rxc;
    logic [6:0]  txc;
    logic        scl_q;
    logic        sda_q;
    logic        sda_oe;
    logic        lvl;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } isc_st_t;

endpackage

// >>> src/isc_sync.sv
// Two-stage synchroniser for pin levels entering the pclk domain.
// Assumes the inputs are asynchronous levels; nothing reads stage one.
`timescale 1ns/1ps

module isc_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Idle bus level is high, so both stages reset to ones.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '1;
      q        <= '1;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // isc_sync

// >>> src/isc_fifo.sv
// Byte FIFO with a fill level, first-word fall-through read and a flush.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps

module isc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = isc_pkg::FIFO_DEPTH,
  parameter int LW    = isc_pkg::LVL_W
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          flush,
  input  wire logic          push,
  input  wire logic [W-1:0]  din,
  input  wire logic          pop,
  output logic      [W-1:0]  dout,
  output logic      [LW-1:0] level,
  output logic               full,
  output logic               empty
);

  logic [W-1:0]  mem [DEPTH];
  logic [LW-2:0] wr_reg;
  logic [LW-2:0] rd_reg;
  logic          do_push;
  logic          do_pop;

  // Pushes into a full FIFO and pops from an empty one are dropped.
  assign full    = (level == LW'(DEPTH));
  assign empty   = (level == '0);
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign dout    = mem[rd_reg];

  // Level moves in the cycle of the push or pop; flush wins over both.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      level  <= '0;
    end
    else if (flush)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      level  <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (do_pop)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
      level <= level + LW'(do_push) - LW'(do_pop);
    end
  end

  // Storage needs no reset; an ADDR_RX_DATA read while empty can return an unwritten word.
  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem[wr_reg] <= din;
    end
  end

endmodule // isc_fifo

// >>> src/isc_top.sv
// I2C SCL timing engine, own-address target and FIFO fill and byte counters.
// Assumes an APB master on pclk and open-drain SCL and SDA resolved outside.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps

module isc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  isc_pkg::isc_st_t s;
  isc_pkg::isc_st_t n;
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       rise;
  logic       fall;
  logic       start_det;
  logic       stop_det;
  logic       acc;
  logic       done_h;
  logic       tx_push;
  logic       tx_pop;
  logic       rx_push;
  logic       rx_pop;
  logic       tt_push;
  logic       tt_pop;
  logic [7:0] rx_din;
  logic [7:0] tx_dout;
  logic [7:0] rx_dout;
  logic [7:0] tt_dout;
  logic [4:0] tx_lvl;
  logic [4:0] rx_lvl;
  logic [4:0] tt_lvl;
  logic       tx_full;
  logic       tx_empty;
  logic       rx_full;
  logic       rx_empty;
  logic       tt_full;
  logic       tt_empty;

  // ****************************************************************
  // Pin synchronisers and FIFOs
  // ****************************************************************
  isc_sync #(.W(2)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({scl_i, sda_i}),
    .q     (pins_s)
  );

  // Master transmit FIFO, sixteen bytes deep.
  isc_fifo u_tx (
    .clk   (pclk),
    .rst_n (presetn),
    .flush (s.srst),
    .push  (tx_push),
    .din   (pwdata[7:0]),
    .pop   (tx_pop),
    .dout  (tx_dout),
    .level (tx_lvl),
    .full  (tx_full),
    .empty (tx_empty)
  );

  isc_fifo u_rx (
    .clk   (pclk),
    .rst_n (presetn),
    .flush (s.srst),
    .push  (rx_push),
    .din   (rx_din),
    .pop   (rx_pop),
    .dout  (rx_dout),
    .level (rx_lvl),
    .full  (rx_full),
    .empty (rx_empty)
  );

  isc_fifo u_tt (
    .clk   (pclk),
    .rst_n (presetn),
    .flush (s.srst),
    .push  (tt_push),
    .din   (pwdata[7:0]),
    .pop   (tt_pop),
    .dout  (tt_dout),
    .level (tt_lvl),
    .full  (tt_full),
    .empty (tt_empty)
  );

  // Edge and bus-condition detection on the synchronised pins only.
  assign scl_s     = pins_s[1];
  assign sda_s     = pins_s[0];
  assign rise      = scl_s && !s.scl_q;
  assign fall      = !scl_s && s.scl_q;
  assign start_det = scl_s && s.scl_q && s.sda_q && !sda_s;
  assign stop_det  = scl_s && s.scl_q && !s.sda_q && sda_s;
  assign acc       = psel && penable && s.pready;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    n       = s;
    n.srst  = 1'b0;
    n.pready  = 1'b0;
    n.pslverr = 1'b0;
    n.scl_q = scl_s;
    n.sda_q = sda_s;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    rx_pop  = 1'b0;
    tt_push = 1'b0;
    tt_pop  = 1'b0;
    rx_din  = 8'h00;
    done_h  = 1'b0;

    // One wait state: read data is captured as pready rises. Reserved bits read zero.
    if (psel && penable && !s.pready)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr)
        isc_pkg::ADDR_HI_DIV:  n.prdata[14:0] = s.hi;
        isc_pkg::ADDR_LO_DIV:  n.prdata[14:0] = s.lo;
        isc_pkg::ADDR_OWN:     n.prdata[6:0]  = s.own;
        isc_pkg::ADDR_RX_LVL:  n.prdata[4:0]  = rx_lvl;
        isc_pkg::ADDR_TX_LVL:  n.prdata[4:0]  = tx_lvl;
        isc_pkg::ADDR_RX_CNT:  n.prdata[6:0]  = s.rxc;
        isc_pkg::ADDR_TX_CNT:  n.prdata[6:0]  = s.txc;
        isc_pkg::ADDR_TT_LVL:  n.prdata[4:0]  = tt_lvl;
        isc_pkg::ADDR_CTRL:    n.prdata[1:0]  = {s.ten, s.men};
        isc_pkg::ADDR_RX_DATA: n.prdata[7:0]  = rx_dout;
        isc_pkg::ADDR_TT_PORT, isc_pkg::ADDR_TX_DATA: n.prdata = 32'h0000_0000;
        default:               n.pslverr      = 1'b1;
      endcase
    end

    // Writes act at the completing edge; reserved bits are dropped.
    if (acc && pwrite)
    begin
      case (paddr)
        isc_pkg::ADDR_HI_DIV:  n.hi = pwdata[14:0];
        isc_pkg::ADDR_LO_DIV:  n.lo = pwdata[14:0];
        isc_pkg::ADDR_OWN:     n.own = pwdata[6:0];
        isc_pkg::ADDR_TT_PORT: tt_push = !tt_full;
        isc_pkg::ADDR_TX_DATA: tx_push = !tx_full;
        isc_pkg::ADDR_CTRL:
        begin
          n.men  = pwdata[isc_pkg::CTRL_MEN];
          n.ten  = pwdata[isc_pkg::CTRL_TEN];
          n.srst = pwdata[isc_pkg::CTRL_SRST];
        end
        default: n.srst = 1'b0;
      endcase
    end
    if (acc && !pwrite && paddr == isc_pkg::ADDR_RX_DATA)
    begin
      rx_pop = !rx_empty;
    end

    // Master: each SCL phase after the start hold is counted from the sensed pin level; M_START counts every cycle.
    case (s.mst)
      isc_pkg::M_IDLE:
      begin
        if (s.men && !tx_empty && s.tgt == isc_pkg::T_IDLE && scl_s && sda_s)
        begin
          n.msda = 1'b1;
          n.cnt  = 15'h0000;
          n.txc  = 7'h00;
          n.mst  = isc_pkg::M_START;
        end
      end
      isc_pkg::M_START:
      begin
        n.cnt = s.cnt + 15'h0001;
        if (n.cnt >= s.hi)
        begin
          n.mscl = 1'b1;
          n.cnt  = 15'h0000;
          n.msh  = tx_dout;
          tx_pop = 1'b1;
          n.mbit = 4'h0;
          n.mst  = isc_pkg::M_LOW;
        end
      end
      isc_pkg::M_LOW, isc_pkg::M_STOP1:
      begin
        if (!scl_s)
        begin
          if (s.cnt == 15'h0000)
          begin
            n.msda = (s.mst == isc_pkg::M_STOP1) ||
                     (s.mbit != isc_pkg::ACK_BIT && !s.msh[7]);
          end
          n.cnt = s.cnt + 15'h0001;
          if (n.cnt >= s.lo)
          begin
            n.mscl = 1'b0;
            n.cnt  = 15'h0000;
            n.mst  = (s.mst == isc_pkg::M_LOW) ? isc_pkg::M_HIGH : isc_pkg::M_STOP2;
          end
        end
      end
      isc_pkg::M_HIGH:
      begin
        // Another master pulling SCL low ends our high phase early.
        if (scl_s)
        begin
          n.cnt  = s.cnt + 15'h0001;
          done_h = (n.cnt >= s.hi);
        end
        else
        begin
          done_h = (s.cnt != 15'h0000);
        end
        if (done_h)
        begin
          n.mscl = 1'b1;
          n.cnt  = 15'h0000;
          n.mst  = isc_pkg::M_LOW;
          if (s.mbit == isc_pkg::ACK_BIT)
          begin
            n.txc = s.txc + 7'h01;
            if (!tx_empty && !sda_s)
            begin
              n.msh  = tx_dout;
              tx_pop = 1'b1;
              n.mbit = 4'h0;
            end
            else
            begin
              n.mst = isc_pkg::M_STOP1;
            end
          end
          else
          begin
            n.mbit = s.mbit + 4'h1;
            n.msh  = {s.msh[6:0], 1'b0};
          end
        end
      end
      isc_pkg::M_STOP2:
      begin
        if (scl_s)
        begin
          n.cnt = s.cnt + 15'h0001;
          if (n.cnt >= s.hi)
          begin
            n.msda = 1'b0;
            n.cnt  = 15'h0000;
            n.mst  = isc_pkg::M_IDLE;
          end
        end
      end
      default: n.mst = isc_pkg::M_IDLE;
    endcase

    // Target: a stop, or a start while the master is idle, overrides whatever byte is in progress.
    if (start_det && s.mst == isc_pkg::M_IDLE)
    begin
      n.tgt  = isc_pkg::T_ADDR;
      n.tbit = 3'h0;
      n.tsda = 1'b0;
    end
    else if (stop_det)
    begin
      n.tgt  = isc_pkg::T_IDLE;
      n.tsda = 1'b0;
    end
    else
    begin
      case (s.tgt)
        isc_pkg::T_ADDR, isc_pkg::T_RX:
        begin
          if (rise)
          begin
            n.tsh  = {s.tsh[6:0], sda_s};
            n.tbit = s.tbit + 3'h1;
            if (s.tbit == isc_pkg::LAST_BIT)
            begin
              n.ackd = 1'b0;
              n.tgt  = isc_pkg::T_ACK;
              if (s.tgt == isc_pkg::T_ADDR)
              begin
                if (s.ten && n.tsh[7:1] == s.own)
                begin
                  n.rw  = n.tsh[0];
                  n.rxc = n.tsh[0] ? s.rxc : 7'h00;
                  n.txc = n.tsh[0] ? 7'h00 : s.txc;
                end
                else
                begin
                  n.tgt = isc_pkg::T_IDLE;
                end
              end
              else
              begin
                rx_push = 1'b1;
                rx_din  = n.tsh;
                n.rxc   = s.rxc + 7'h01;
              end
            end
          end
        end
        isc_pkg::T_ACK:
        begin
          if (fall && !s.ackd)
          begin
            n.tsda = 1'b1;
            n.ackd = 1'b1;
          end
          else if (fall)
          begin
            n.tbit = 3'h0;
            n.tsda = 1'b0;
            n.tgt  = isc_pkg::T_RX;
            if (s.rw)
            begin
              // An empty target FIFO sends all ones rather than stale data.
              n.tsh  = tt_empty ? 8'hFF : tt_dout;
              tt_pop = 1'b1;
              n.tsda = !n.tsh[7];
              n.tgt  = isc_pkg::T_TX;
            end
          end
        end
        isc_pkg::T_TX:
        begin
          if (fall)
          begin
            n.tbit = s.tbit + 3'h1;
            if (s.tbit == isc_pkg::LAST_BIT)
            begin
              n.tsda = 1'b0;
              n.txc  = s.txc + 7'h01;
              n.tgt  = isc_pkg::T_TXACK;
            end
            else
            begin
              n.tsh  = {s.tsh[6:0], 1'b0};
              n.tsda = !n.tsh[7];
            end
          end
        end
        isc_pkg::T_TXACK:
        begin
          if (rise)
          begin
            n.tack = !sda_s;
          end
          else if (fall && s.tack)
          begin
            n.tsh  = tt_empty ? 8'hFF : tt_dout;
            tt_pop = 1'b1;
            n.tsda = !n.tsh[7];
            n.tbit = 3'h0;
            n.tgt  = isc_pkg::T_TX;
          end
          else if (fall)
          begin
            n.tgt = isc_pkg::T_IDLE;
          end
        end
        default: n.tgt = isc_pkg::T_IDLE;
      endcase
    end

    // Soft reset keeps divisors and own address; it idles both machines and clears SCL/SDA drive, cnt, rxc, txc, men, ten and the FIFOs.
    if (s.srst)
    begin
      n.mst  = isc_pkg::M_IDLE;
      n.tgt  = isc_pkg::T_IDLE;
      n.mscl = 1'b0;
      n.msda = 1'b0;
      n.tsda = 1'b0;
      n.cnt  = 15'h0000;
      n.rxc  = 7'h00;
      n.txc  = 7'h00;
      n.men  = 1'b0;
      n.ten  = 1'b0;
    end
    n.sda_oe = n.msda || n.tsda;
    n.lvl    = 1'b0;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s       <= '0;
      s.hi    <= isc_pkg::DIV_RESET;
      s.lo    <= isc_pkg::DIV_RESET;
      s.own   <= isc_pkg::OWN_RESET;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.mst   <= isc_pkg::M_IDLE;
      s.tgt   <= isc_pkg::T_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign scl_o   = s.lvl;
  assign scl_oe  = s.mscl;
  assign sda_o   = s.lvl;
  assign sda_oe  = s.sda_oe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LOW_DIV: assert property (s.mst == isc_pkg::M_LOW && !scl_s &&
    s.cnt + 15'h0001 >= s.lo && !s.srst |=> !scl_oe && s.mst == isc_pkg::M_HIGH)
    else $error("SCL not released after low divisor.");
  AST_HIGH_ABORT: assert property (s.mst == isc_pkg::M_HIGH && !scl_s &&
    s.cnt != 15'h0000 && !s.srst |=> scl_oe)
    else $error("High count not abandoned on foreign SCL low.");
  AST_ADDR_MISS: assert property (s.tgt == isc_pkg::T_ADDR && rise &&
    s.tbit == isc_pkg::LAST_BIT && {s.tsh[6:0], sda_s} >> 1 != s.own
    && !start_det && !stop_det && !s.srst |=> s.tgt == isc_pkg::T_IDLE)
    else $error("Target answered a foreign address.");
  AST_RX_LVL: assert property (rx_push && !rx_full && !rx_pop && !s.srst
    |=> rx_lvl == $past(rx_lvl) + 5'h01)
    else $error("Receive level did not follow push.");
  AST_TX_LVL: assert property (tx_lvl <= 5'h10)
    else $error("Transmit level beyond depth.");
  AST_RX_CNT: assert property (!$stable(s.rxc) |-> s.rxc == 7'h00 ||
    s.rxc == $past(s.rxc) + 7'h01)
    else $error("Receive counter jumped.");
  AST_TX_CNT: assert property (!$stable(s.txc) |-> s.txc == 7'h00 ||
    s.txc == $past(s.txc) + 7'h01)
    else $error("Sent counter jumped.");
  AST_TT_PUSH: assert property (acc && pwrite && paddr == isc_pkg::ADDR_TT_PORT
    && !tt_full && !tt_pop && !s.srst |=> tt_lvl == $past(tt_lvl) + 5'h01)
    else $error("Target port write not queued.");
  AST_TT_LVL: assert property (tt_lvl <= 5'h10)
    else $error("Target level beyond depth.");
  AST_MSB: assert property (s.tgt == isc_pkg::T_TXACK && fall && s.tack
    && !tt_empty && !start_det && !stop_det && !s.srst |=> s.tsda == !$past(tt_dout[7]))
    else $error("Target byte not started with bit 7.");
  AST_SRST: assert property (s.srst |=> rx_lvl == 5'h00 && tx_lvl == 5'h00
    && tt_lvl == 5'h00 && s.hi == $past(s.hi) && s.own == $past(s.own))
    else $error("Soft reset did not flush or changed settings.");

endmodule // isc_top

// >>> test/isc_bus_model.sv
// I2C target stand-in that acknowledges every byte and records the first one.
// Assumes resolved open-drain levels with pull-ups on scl and sda.
`timescale 1ns/1ps

module isc_bus_model (
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  output logic      [7:0] first_byte,
  output logic            stopped
);
  logic [7:0] sh = 8'h00;
  int         bits = 0;
  int         nbyte = 0;

  // ****************************************************************
  // Framing and acknowledge
  // ****************************************************************
  // A start opens a frame; a stop is remembered so the bench can poll for it.
  initial
  begin
    sda_oe = 1'b0;
    stopped = 1'b0;
    first_byte = 8'h00;
  end
  always @(negedge sda)
    if (scl)
    begin
      bits = 0;
      stopped = 1'b0; // Power-up edges on the lines can look like a stop.
    end
  always @(posedge sda)
    if (scl)
      stopped = 1'b1;
  // Data shift on each SCL rise; the ninth rise is the acknowledge slot.
  always @(posedge scl)
    if (bits < 8)
    begin
      sh = {sh[6:0], sda};
      bits++;
      if (bits == 8 && nbyte == 0)
        first_byte = sh;
    end
    else
    begin
      bits = 0;
      nbyte++;
    end
  // SDA is pulled low only across the acknowledge bit, released otherwise.
  always @(negedge scl)
    sda_oe = (bits == 8);
endmodule // isc_bus_model

// >>> test/isc_top_tb.sv
// Bench for isc_top: reset values, divisors, target FIFO fill and flush, one master byte.
// Assumes isc_bus_model is the only other party on the pulled-up I2C lines.
`timescale 1ns/1ps

module isc_top_tb;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} isc_exp_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic        scl_o, scl_oe, sda_o, sda_oe, m_oe, stopped;
  logic [7:0]  first_byte, b;
  logic [6:0]  own;
  wire         scl_w = !scl_oe;
  wire         sda_w = !(sda_oe || m_oe);
  isc_exp_t    q[$];
  isc_exp_t    x;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;

  isc_top isc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe));
  isc_bus_model isc_bus_model_i (.scl(scl_w), .sda(sda_w), .sda_oe(m_oe),
    .first_byte(first_byte), .stopped(stopped));

  // ****************************************************************
  // Clock, checking and closing
  // ****************************************************************
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic check(input bit ok, input string s);
    num_checks++;
    if (!ok)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // The oldest queued note is matched against each completed transfer.
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      stop_test();
    end
    if (psel && penable && pready)
    begin
      x = q.pop_front();
      check(((prdata & x.m) === x.d) && (pslverr === x.e), "apb answer");
    end
  end
  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [31:0] a, d, m, input logic e);
    q.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [31:0] a, d, m);
    apb(1'b0, a, d, m, 1'b0);
  endtask
  // Cycles until the resolved SCL leaves level v; sync and register delay add a few.
  task automatic phase(input logic v, input int div, input string s);
    n = 0;
    while (scl_w === v && n < 100000)
    begin
      @(posedge pclk);
      n++;
    end
    check(n >= div + 1 && n <= div + 5, s);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    void'($urandom(13174));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(isc_pkg::ADDR_HI_DIV, 32'h752E, 32'h7FFF);
    rd(isc_pkg::ADDR_LO_DIV, 32'h752E, 32'h7FFF);
    rd(isc_pkg::ADDR_OWN, 32'h1A, 32'h7F);
    rd(isc_pkg::ADDR_RX_LVL, 32'h0, 32'h1F);
    rd(isc_pkg::ADDR_TX_LVL, 32'h0, 32'h1F);
    rd(isc_pkg::ADDR_RX_CNT, 32'h0, 32'h7F);
    rd(isc_pkg::ADDR_TX_CNT, 32'h0, 32'h7F);
    rd(isc_pkg::ADDR_TT_LVL, 32'h0, 32'h1F);
    apb(1'b0, 32'h8002_0840, 32'h0, 32'h0, 1'b1);
    $display("test reset_values done");
    own = 7'($urandom());
    // Unequal phases; 125 MHz over 320 cycles keeps the bit rate under 400 kHz.
    wr(isc_pkg::ADDR_LO_DIV, 32'h96);
    wr(isc_pkg::ADDR_HI_DIV, 32'hAA);
    wr(isc_pkg::ADDR_OWN, {25'h0, own});
    rd(isc_pkg::ADDR_LO_DIV, 32'h96, 32'h7FFF);
    rd(isc_pkg::ADDR_OWN, {25'h0, own}, 32'h7F);
    $display("test divisors done");
    for (int i = 1; i <= 16; i++)
    begin
      wr(isc_pkg::ADDR_TT_PORT, {24'h0, 8'($urandom())});
      rd(isc_pkg::ADDR_TT_LVL, 32'(i), 32'h1F);
    end
    wr(isc_pkg::ADDR_CTRL, 32'h100);
    rd(isc_pkg::ADDR_TT_LVL, 32'h0, 32'h1F);
    rd(isc_pkg::ADDR_HI_DIV, 32'hAA, 32'h7FFF);
    rd(isc_pkg::ADDR_OWN, {25'h0, own}, 32'h7F);
    $display("test target_fifo done");
    b = 8'($urandom());
    wr(isc_pkg::ADDR_TX_DATA, {24'h0, b});
    rd(isc_pkg::ADDR_TX_LVL, 32'h1, 32'h1F);
    wr(isc_pkg::ADDR_CTRL, 32'h1);
    @(posedge scl_w);
    phase(1'b1, 170, "scl high phase");
    phase(1'b0, 150, "scl low phase");
    n = 0;
    while (!stopped && n < 6000)
    begin
      @(posedge pclk);
      n++;
    end
    check(stopped === 1'b1, "no stop after last byte");
    check(first_byte === b, "byte order on sda");
    rd(isc_pkg::ADDR_TX_LVL, 32'h0, 32'h1F);
    rd(isc_pkg::ADDR_TX_CNT, 32'h1, 32'h7F);
    $display("test master_byte done");
    @(posedge pclk);
    stop_test();
  end
endmodule // isc_top_tb
